/* File: inc/ucg_pkg.sv */
`default_nettype none
package ucg_pkg;

   // Register byte addresses
   localparam logic [7:0] UCG_CSR_OFS   = 8'h00;
   localparam logic [7:0] UCG_RXD_OFS   = 8'h04;
   localparam logic [7:0] UCG_TXD_OFS   = 8'h08;
   localparam logic [7:0] UCG_RXCNT_OFS = 8'h0C;
   localparam logic [7:0] UCG_TXCNT_OFS = 8'h10;

   // Field positions
   localparam int UCG_FREEZE_BIT = 3;
   localparam int UCG_VALID_BIT  = 2;
   localparam int UCG_TRIG_BIT   = 0;

   // Reset values
   localparam logic [7:0] UCG_CSR_RESET = 8'h00;
   localparam logic [7:0] UCG_BYTE_ZERO = 8'h00;

   // Sizes
   localparam int UCG_FIFO_DEPTH = 8;
   localparam int UCG_CFG_BYTES  = 8;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } ucg_byte_t;

endpackage : ucg_pkg
`default_nettype wire

/* File: rtl/ucg_ep0_guard.sv */
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - System reset or function soft reset clears the whole control/status register to zero.
// - Bits 7 to 4 of the control/status register read as zero and ignore writes.
// - While the freeze bit is 1 the SETUP data in the endpoint 0 receive FIFO is kept intact.
// - While frozen, reading the receive data port leaves the receive valid count unchanged.
// - While frozen, writes to the transmit data port leave the transmit FIFO unchanged.
// - While frozen, the transmit trigger leaves the transmit valid count unchanged.
// - With the freeze bit at 0 and the valid bit at 1 both endpoint 0 FIFOs read, write and trigger normally.
// - After any reset the core holds no endpoint configuration and stays idle until given one.
// - Software sets the valid bit after the last byte, and the loaded configuration then counts.
// - The valid bit enables the core; while it is 0 the core stays inactive.
module ucg_ep0_guard
   import ucg_pkg::*;
#(
   parameter int DEPTH = UCG_FIFO_DEPTH,
   parameter int CFGN  = UCG_CFG_BYTES
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   input  wire logic              func_soft_reset,
   input  wire ucg_byte_t         rx_in,
   output var  logic              rx_room,
   input  wire logic              tx_pop,
   output var  ucg_byte_t         tx_out,
   output var  logic              ep_zero_freeze,
   output var  logic              endpoint_config_valid,
   output var  logic [CFGN*8-1:0] endpoint_configuration
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int IW = $clog2(CFGN + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [IW-1:0] CFG_LAST = IW'(CFGN);

   logic            setup;
   logic            acc;
   logic            wr_csr;
   logic            wr_txd;
   logic            wr_trig;
   logic            rd_rxd;
   logic            hit;
   logic [31:0]     next_rdata;
   logic            rx_rd_ok;

   logic [7:0]      rx_mem [DEPTH];
   logic [PW-1:0]   rx_wp;
   logic [PW-1:0]   rx_rp;
   logic [CW-1:0]   rx_cnt;
   logic [CW-1:0]   next_rx_cnt;
   logic            rx_push;
   logic            rx_pop;

   logic [7:0]      tx_mem [DEPTH];
   logic [PW-1:0]   tx_wp;
   logic [PW-1:0]   tx_rp;
   logic [CW-1:0]   tx_cnt;
   logic [CW-1:0]   tx_stage;
   logic [CW-1:0]   next_tx_cnt;
   logic            tx_wr;
   logic            tx_trig;
   logic            tx_take;

   logic [IW-1:0]   cfg_idx;

   // APB decode; effects land only at the completing edge
   assign setup   = psel & ~penable;
   assign acc     = psel & penable & pready;
   assign wr_csr  = acc & pwrite & (paddr == UCG_CSR_OFS);
   assign wr_txd  = acc & pwrite & (paddr == UCG_TXD_OFS);
   assign wr_trig = acc & pwrite & (paddr == UCG_TXCNT_OFS);
   assign rd_rxd  = acc & ~pwrite & (paddr == UCG_RXD_OFS);

   always_comb begin
      hit        = 1'b1;
      next_rdata = 32'h0000_0000;
      case (paddr)
         UCG_CSR_OFS: begin
            next_rdata[UCG_FREEZE_BIT] = ep_zero_freeze;
            next_rdata[UCG_VALID_BIT]  = endpoint_config_valid;
         end
         UCG_RXD_OFS: begin
            if (rx_cnt != '0) begin
               next_rdata[7:0] = rx_mem[rx_rp];
            end
         end
         UCG_TXD_OFS:   next_rdata = 32'h0000_0000;
         UCG_RXCNT_OFS: next_rdata = 32'(rx_cnt);
         UCG_TXCNT_OFS: next_rdata = 32'(tx_cnt);
         default:       hit = 1'b0;
      endcase
   end

   // One access cycle: pready rises the cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready   <= 1'b0;
         prdata   <= 32'h0000_0000;
         pslverr  <= 1'b0;
         rx_rd_ok <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata   <= next_rdata;
            pslverr  <= ~hit;
            // Pop only what was actually returned, not a byte that arrived later
            rx_rd_ok <= (rx_cnt != '0);
         end
      end
   end

   // Control/status bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ep_zero_freeze        <= UCG_CSR_RESET[UCG_FREEZE_BIT];
         endpoint_config_valid <= UCG_CSR_RESET[UCG_VALID_BIT];
      end else if (func_soft_reset) begin
         ep_zero_freeze        <= UCG_CSR_RESET[UCG_FREEZE_BIT];
         endpoint_config_valid <= UCG_CSR_RESET[UCG_VALID_BIT];
      end else if (wr_csr) begin
         ep_zero_freeze <= pwdata[UCG_FREEZE_BIT];
         if (pwdata[UCG_VALID_BIT]) begin
            endpoint_config_valid <= 1'b1;
         end
      end
   end

   // Configuration bytes load in order until the valid bit closes the window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_idx                <= '0;
         endpoint_configuration <= '0;
      end else if (func_soft_reset) begin
         cfg_idx                <= '0;
         endpoint_configuration <= '0;
      end else if (wr_txd && !endpoint_config_valid && !ep_zero_freeze &&
                   cfg_idx != CFG_LAST) begin
         endpoint_configuration[cfg_idx*8 +: 8] <= pwdata[7:0];
         cfg_idx <= cfg_idx + 1'b1;
      end
   end

   // Receive FIFO, filled by the core, drained by the data port
   assign rx_push = rx_in.valid & rx_room & endpoint_config_valid;
   assign rx_pop  = rd_rxd & rx_rd_ok & ~ep_zero_freeze;
   assign next_rx_cnt = rx_cnt + CW'(rx_push) - CW'(rx_pop);

   always_ff @(posedge pclk) begin
      if (rx_push) begin
         rx_mem[rx_wp] <= rx_in.data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_wp   <= '0;
         rx_rp   <= '0;
         rx_cnt  <= '0;
         rx_room <= 1'b1;
      end else if (func_soft_reset) begin
         rx_wp   <= '0;
         rx_rp   <= '0;
         rx_cnt  <= '0;
         rx_room <= 1'b1;
      end else begin
         if (rx_push) begin
            rx_wp <= rx_wp + 1'b1;
         end
         if (rx_pop) begin
            rx_rp <= rx_rp + 1'b1;
         end
         rx_cnt  <= next_rx_cnt;
         rx_room <= (next_rx_cnt != FULL);
      end
   end

   // Transmit FIFO: written bytes wait in a staged count until the trigger
   assign tx_wr   = wr_txd & endpoint_config_valid & ~ep_zero_freeze &
                    ((tx_stage + tx_cnt) != FULL);
   assign tx_trig = wr_trig & pwdata[UCG_TRIG_BIT] & endpoint_config_valid &
                    ~ep_zero_freeze;
   assign tx_take = tx_pop & (tx_cnt != '0) & endpoint_config_valid;
   assign next_tx_cnt = tx_cnt + (tx_trig ? tx_stage : '0) - CW'(tx_take);

   always_ff @(posedge pclk) begin
      if (tx_wr) begin
         tx_mem[tx_wp] <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_wp    <= '0;
         tx_rp    <= '0;
         tx_cnt   <= '0;
         tx_stage <= '0;
         tx_out   <= '0;
      end else if (func_soft_reset) begin
         tx_wp    <= '0;
         tx_rp    <= '0;
         tx_cnt   <= '0;
         tx_stage <= '0;
         tx_out   <= '0;
      end else begin
         if (tx_wr) begin
            tx_wp <= tx_wp + 1'b1;
         end
         if (tx_trig) begin
            tx_stage <= '0;
         end else if (tx_wr) begin
            tx_stage <= tx_stage + 1'b1;
         end
         tx_cnt       <= next_tx_cnt;
         tx_out.valid <= tx_take;
         if (tx_take) begin
            tx_out.data <= tx_mem[tx_rp];
            tx_rp       <= tx_rp + 1'b1;
         end
      end
   end

   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_frozen_rx_read;
      rd_rxd && ep_zero_freeze;
   endsequence

   sequence s_frozen_trig;
      wr_trig && pwdata[UCG_TRIG_BIT] && ep_zero_freeze;
   endsequence

   sequence s_live_rx_read;
      rd_rxd && rx_rd_ok && !ep_zero_freeze && !rx_push;
   endsequence

   a_soft_reset_clears: assert property (
      func_soft_reset |=> !ep_zero_freeze && !endpoint_config_valid && rx_cnt == '0 && tx_cnt == '0)
      else $error("soft reset left state behind");

   a_reserved_read_zero: assert property (
      setup && !pwrite && paddr == UCG_CSR_OFS |=> prdata[31:4] == 28'h0000000 && pready)
      else $error("reserved bits not zero");

   a_setup_data_kept: assert property (
      ep_zero_freeze && !func_soft_reset |=> $stable(rx_rp))
      else $error("receive data consumed while frozen");

   a_frozen_rx_count: assert property (
      s_frozen_rx_read ##0 !func_soft_reset |=> rx_cnt >= $past(rx_cnt))
      else $error("receive count dropped while frozen");

   a_frozen_tx_write: assert property (
      wr_txd && ep_zero_freeze && !func_soft_reset |=> $stable(tx_wp) && $stable(tx_stage))
      else $error("transmit FIFO changed while frozen");

   a_frozen_trig_hold: assert property (
      s_frozen_trig ##0 !func_soft_reset |=> tx_cnt <= $past(tx_cnt))
      else $error("transmit count grew while frozen");

   a_live_rx_pop: assert property (
      s_live_rx_read ##0 !func_soft_reset |=> rx_cnt == $past(rx_cnt) - 1'b1)
      else $error("normal receive read did not pop");

   a_idle_until_valid: assert property (
      !endpoint_config_valid |=> !tx_out.valid && rx_cnt == $past(rx_cnt) - CW'($past(rx_pop)))
      else $error("core active without configuration");

   a_valid_sticky: assert property (
      endpoint_config_valid && !func_soft_reset |=> endpoint_config_valid)
      else $error("valid bit dropped without reset");

   a_valid_by_write: assert property (
      wr_csr && pwdata[UCG_VALID_BIT] && !func_soft_reset |=> endpoint_config_valid)
      else $error("valid bit not set by write");

   // Bus handshake: one access cycle per setup, error only off the map
   sequence s_apb_setup;
      psel && !penable;
   endsequence

   sequence s_one_access;
      pready ##1 !pready;
   endsequence

   sequence s_cfg_write;
      wr_txd && !endpoint_config_valid && !ep_zero_freeze && cfg_idx != CFG_LAST;
   endsequence

   sequence s_push_only;
      rx_push && !rx_pop;
   endsequence

   a_single_access: assert property (
      s_apb_setup |=> s_one_access)
      else $error("access phase not exactly one cycle");

   a_unmapped_error: assert property (
      setup && !hit |=> pready && pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not flagged");

   a_mapped_no_error: assert property (
      setup && hit |=> pready && !pslverr)
      else $error("mapped access flagged as error");

   a_rx_head_data: assert property (
      rd_rxd && rx_rd_ok |-> prdata[7:0] == rx_mem[rx_rp])
      else $error("receive read returned wrong byte");

   // Head byte of a frozen FIFO must survive later pushes
   a_frozen_rx_data: assert property (
      ep_zero_freeze && rx_cnt != '0 && !func_soft_reset |=> rx_mem[rx_rp] == $past(rx_mem[rx_rp]))
      else $error("frozen receive head overwritten");

   a_rx_push_count: assert property (
      s_push_only ##0 !func_soft_reset |=> rx_cnt == $past(rx_cnt) + 1'b1)
      else $error("received byte not counted");

   a_trig_commit: assert property (
      tx_trig && !tx_take && !func_soft_reset |=> tx_cnt == $past(tx_cnt) + $past(tx_stage))
      else $error("trigger did not commit staged bytes");

   a_tx_out_pulse: assert property (
      !func_soft_reset |=> tx_out.valid == $past(tx_take))
      else $error("transmit strobe not one cycle");

   // Configuration is taken once, in order, then locked by the valid bit
   a_cfg_byte_order: assert property (
      s_cfg_write ##0 !func_soft_reset |=> cfg_idx == $past(cfg_idx) + 1'b1)
      else $error("configuration byte not taken in order");

   a_config_locked: assert property (
      endpoint_config_valid && !func_soft_reset |=> $stable(endpoint_configuration))
      else $error("configuration changed after it was validated");

endmodule : ucg_ep0_guard
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb
   import ucg_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, func_soft_reset;
   logic        rx_room, tx_pop, ep_zero_freeze, endpoint_config_valid, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [63:0] endpoint_configuration;
   logic [8:0]  got;
   ucg_byte_t   rx_in, tx_out;
   int          errors, n_tests;

   ucg_ep0_guard dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .func_soft_reset, .rx_in, .rx_room, .tx_pop, .tx_out, .ep_zero_freeze,
      .endpoint_config_valid, .endpoint_configuration);
   ucg_core_model core (.pclk, .rx_room, .tx_out, .rx_in, .tx_pop);

   always #4 pclk = ~pclk;

   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Leaves psel up so that a following call makes a back-to-back transfer
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
   endtask : apb

   task automatic idle;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : idle

   task automatic t_reset_map;
      apb(0, UCG_CSR_OFS, 0);       chk("csr", r, 0);
      apb(1, UCG_CSR_OFS, 32'hF0);
      apb(0, UCG_CSR_OFS, 0);       chk("csr", r, 0);
      apb(0, 8'h40, 0);             chk("slverr", e, 1);
      idle();
      chk("valid", endpoint_config_valid, 0);
   endtask : t_reset_map

   task automatic t_config;
      core.push(8'h3C);
      apb(0, UCG_RXCNT_OFS, 0);     chk("rxcnt", r, 0);
      for (int k = 0; k < 8; k++) begin
         apb(1, UCG_TXD_OFS, 32'h11 * (k + 1));
      end
      apb(1, UCG_CSR_OFS, 32'h04);
      apb(1, UCG_CSR_OFS, 32'h00);
      apb(0, UCG_CSR_OFS, 0);       chk("csr", r, 32'h04);
      idle();
      chk("valid", endpoint_config_valid, 1);
      chk("config", endpoint_configuration, 64'h8877665544332211);
   endtask : t_config

   task automatic t_normal;
      core.push(8'hA1);
      core.push(8'hB2);
      apb(0, UCG_RXCNT_OFS, 0);     chk("rxcnt", r, 2);
      apb(0, UCG_RXD_OFS, 0);       chk("rxd", r, 32'hA1);
      apb(0, UCG_RXCNT_OFS, 0);     chk("rxcnt", r, 1);
      apb(1, UCG_TXD_OFS, 32'hC3);
      apb(1, UCG_TXD_OFS, 32'hD4);
      apb(1, UCG_TXCNT_OFS, 32'h01);
      apb(0, UCG_TXCNT_OFS, 0);     chk("txcnt", r, 2);
      idle();
      core.pop(got);                chk("tx", got, 9'h1C3);
   endtask : t_normal

   task automatic t_freeze;
      apb(1, UCG_CSR_OFS, 32'h08);
      apb(0, UCG_CSR_OFS, 0);       chk("csr", r, 32'h0C);
      chk("freeze", ep_zero_freeze, 1);
      apb(0, UCG_RXD_OFS, 0);       chk("rxd", r, 32'hB2);
      apb(0, UCG_RXCNT_OFS, 0);     chk("rxcnt", r, 1);
      apb(1, UCG_TXD_OFS, 32'h77);
      apb(1, UCG_TXCNT_OFS, 32'h01);
      apb(0, UCG_TXCNT_OFS, 0);     chk("txcnt", r, 1);
      apb(1, UCG_CSR_OFS, 32'h00);
      apb(1, UCG_TXCNT_OFS, 32'h01);
      apb(0, UCG_TXCNT_OFS, 0);     chk("txcnt", r, 1);
      apb(0, UCG_RXD_OFS, 0);       chk("rxd", r, 32'hB2);
      idle();
      core.pop(got);                chk("tx", got, 9'h1D4);
   endtask : t_freeze

   task automatic t_soft;
      apb(1, UCG_CSR_OFS, 32'h08);
      idle();
      core.push(8'hE5);
      func_soft_reset <= 1'b1;
      @(posedge pclk);
      func_soft_reset <= 1'b0;
      apb(0, UCG_CSR_OFS, 0);       chk("csr", r, 0);
      apb(0, UCG_RXCNT_OFS, 0);     chk("rxcnt", r, 0);
      idle();
      chk("config", endpoint_configuration, 0);
      chk("room", rx_room, 1);
      // Second system reset in mid-run, with both control bits set
      apb(1, UCG_CSR_OFS, 32'h0C);
      idle();
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      apb(0, UCG_CSR_OFS, 0);       chk("csr", r, 0);
      idle();
      chk("valid", endpoint_config_valid, 0);
      chk("freeze", ep_zero_freeze, 0);
   endtask : t_soft

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = 0; pwdata = 0; func_soft_reset = 0; errors = 0; n_tests = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_map();
      t_config();
      t_normal();
      t_freeze();
      t_soft();
      report_and_stop();
   end

   // All scenarios take about a hundred cycles
   initial begin
      repeat (5000) @(posedge pclk);
      errors++;
      report_and_stop();
   end
endmodule : tb
`default_nettype wire

/* File: tb/ucg_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Stands in for the function core logic that faces the host
module ucg_core_model
   import ucg_pkg::*;
(
   input  wire logic      pclk,
   input  wire logic      rx_room,
   input  wire ucg_byte_t tx_out,
   output var  ucg_byte_t rx_in,
   output var  logic      tx_pop
);
   initial begin
      rx_in  = '{valid: 1'b0, data: 8'h5A};
      tx_pop = 1'b0;
   end

   task automatic push(input logic [7:0] b);
      while (rx_room !== 1'b1) begin
         @(posedge pclk);
      end
      rx_in <= '{valid: 1'b1, data: b};
      @(posedge pclk);
      // Released data shows the inverse so a stale byte is never mistaken for a fresh one
      rx_in <= '{valid: 1'b0, data: ~b};
      // One idle edge, so back-to-back calls never drive rx_in twice in one step
      @(posedge pclk);
   endtask : push

   task automatic pop(output logic [8:0] got);
      tx_pop <= 1'b1;
      @(posedge pclk);
      tx_pop <= 1'b0;
      @(posedge pclk);
      got = tx_out;
   endtask : pop
endmodule : ucg_core_model
`default_nettype wire
